// ==== pkg/multidrop_pkg.sv ====
package multidrop_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;

   // Register addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_NODES = 4'h1;
   localparam logic [3:0] ADDR_PRIO = 4'h2;
   localparam logic [3:0] ADDR_SLICE = 4'h3;
   localparam logic [3:0] ADDR_DROP = 4'h4;
   localparam logic [3:0] ADDR_REPLY = 4'h5;
   localparam logic [3:0] ADDR_TXDATA = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;

   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DRV_LO = 1;
   localparam int TXDATA_LAST_BIT = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_FULL_BIT = 1;
   localparam int ST_EMPTY_BIT = 2;
   localparam int ST_REPLY_OK_BIT = 3;
   localparam int ST_REPLY_TO_BIT = 4;
   localparam int ST_RTS_BIT = 5;
   localparam int ST_SLOT_LO = 8;

   // Driver settings
   localparam logic [1:0] DRV_FULL_DUPLEX = 2'h0;
   localparam logic [1:0] DRV_HALF_DUPLEX = 2'h1;
   localparam logic [1:0] DRV_TWO_WIRE = 2'h2;

   // Reset values
   localparam logic [7:0] RST_NODES = 8'h01;
   localparam logic [7:0] RST_PRIO = 8'h01;
   localparam logic [7:0] RST_SLICE = 8'h05;
   localparam logic [7:0] RST_DROP = 8'h00;
   localparam logic [7:0] RST_REPLY = 8'h32;
   localparam logic [1:0] RST_DRV = DRV_FULL_DUPLEX;
   localparam logic [7:0] FIRST_SLOT = 8'h01;

   // Timing: one hundredth of a second at the system clock
   localparam longint CLK_PERIOD_NS = 50;
   localparam longint HUNDREDTH_NS = 10000000;
   localparam int HUNDREDTH_CYCLES = int'(HUNDREDTH_NS / CLK_PERIOD_NS);
   localparam int TICK_W = 24;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } line_byte_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_SLOT,
      ST_WAIT_CTS,
      ST_SEND,
      ST_WAIT_REPLY
   } tx_state_t;
endpackage

// ==== rtl/byte_fifo.sv ====
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr;
      logic [PTR_W-1:0] rd;
      logic [CNT_W-1:0] count;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t next_s;
   logic push;
   logic pop;

   assign in_ready = (s.count != FULL_CNT);
   assign out_valid = (s.count != '0);
   assign out_data = s.mem[s.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = (s.wr == LAST_PTR) ? '0 : s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = (s.rd == LAST_PTR) ? '0 : s.rd + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // byte_fifo

// ==== rtl/multidrop_line_arbiter.sv ====
// How it works
// R1: Line shared by time division slots, never by collision detection.
// R2: Slot turn comes from configured node count and own priority.
// R3: Raise RTS, wait CTS, send packet, then await reply from target.
// R4: Watch all traffic, accept own drop address, forward accepted packets.
// R5: Software sets the same node count and slice on every node.
// R6: Priority unique on line, within one to node count.
// R7: Slice about four character times plus worst RTS-to-CTS delay.
// R8: Slice setting never below five hundredths of a second.
// R9: Works whether or not own transmit data echoes back.
// R10: Line interface delivers to all nodes, accepts data while CTS.
// R11: Full duplex setting: driver always on, receiver always on.
// R12: Half duplex setting: driver always on, receiver off while sending.
// R13: Two-wire setting: driver follows CTS, receiver off while sending.
// R14: Start only in own priority slot; slots cycle one to node count.
module multidrop_line_arbiter #(
   parameter int HUNDREDTH_CYCLES = multidrop_pkg::HUNDREDTH_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [multidrop_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [multidrop_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [multidrop_pkg::DATA_W-1:0] reg_rdata,
   output logic line_rts,
   input wire logic line_cts,
   output logic [7:0] line_tx_data,
   output logic line_tx_last,
   output logic line_tx_valid,
   input wire logic line_tx_ready,
   input wire logic [7:0] line_rx_data,
   input wire logic line_rx_last,
   input wire logic line_rx_valid,
   output logic line_drv_en,
   output logic line_rcv_en,
   output logic [7:0] fwd_data,
   output logic fwd_last,
   output logic fwd_valid
);
   localparam logic [multidrop_pkg::TICK_W-1:0] TICK_LAST =
      multidrop_pkg::TICK_W'(HUNDREDTH_CYCLES - 1);

   typedef struct packed {
      multidrop_pkg::tx_state_t st;
      logic enable;
      logic [1:0] drv;
      logic [7:0] nodes;
      logic [7:0] prio;
      logic [7:0] slice;
      logic [7:0] drop;
      logic [7:0] reply;
      logic [multidrop_pkg::TICK_W-1:0] tick_cnt;
      logic [7:0] slice_cnt;
      logic [7:0] slot;
      logic [7:0] wait_cnt;
      logic rx_first;
      logic rx_accept;
      logic [7:0] fwd_data;
      logic fwd_last;
      logic fwd_valid;
      logic reply_ok;
      logic reply_to;
      logic [multidrop_pkg::DATA_W-1:0] rdata;
   } arb_state_t;

   arb_state_t s;
   arb_state_t next_s;

   multidrop_pkg::line_byte_t fifo_in;
   multidrop_pkg::line_byte_t fifo_out;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic tick;
   logic slice_end;
   logic own_slot;
   logic sending;
   logic rx_take;
   logic rx_ours;
   logic [multidrop_pkg::DATA_W-1:0] status;

   assign fifo_in.data = reg_wdata[7:0];
   assign fifo_in.last = reg_wdata[multidrop_pkg::TXDATA_LAST_BIT];
   assign fifo_in_valid = reg_wr && (reg_addr == multidrop_pkg::ADDR_TXDATA);

   // Full queue drops the word; software polls the full flag first
   byte_fifo #(
      .WIDTH($bits(multidrop_pkg::line_byte_t)),
      .DEPTH(multidrop_pkg::FIFO_DEPTH)
   ) tx_queue (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   assign tick = (s.tick_cnt == TICK_LAST);
   assign slice_end = tick && ((s.slice_cnt + 8'h01) >= s.slice);
   assign own_slot = (s.slot == s.prio); // R2
   assign sending = (s.st == multidrop_pkg::ST_WAIT_CTS) || (s.st == multidrop_pkg::ST_SEND);

   // Bytes leave only while CTS holds
   assign line_rts = sending; // R3
   assign line_tx_data = fifo_out.data;
   assign line_tx_last = fifo_out.last;
   assign line_tx_valid = (s.st == multidrop_pkg::ST_SEND) && fifo_out_valid && line_cts; // R3
   assign fifo_out_ready = line_tx_valid && line_tx_ready;

   always_comb begin
      line_drv_en = 1'b1; // R11 R12
      line_rcv_en = 1'b1; // R11
      case (s.drv)
         multidrop_pkg::DRV_HALF_DUPLEX: begin
            line_rcv_en = !sending; // R12
         end
         multidrop_pkg::DRV_TWO_WIRE: begin
            line_drv_en = line_cts; // R13
            line_rcv_en = !sending; // R13
         end
         default: begin
            line_rcv_en = 1'b1;
         end
      endcase
   end

   // Echoed own packets carry a foreign address and are filtered out
   assign rx_take = line_rx_valid && line_rcv_en && s.enable; // R4 R9
   assign rx_ours = s.rx_first ? (line_rx_data == s.drop) : s.rx_accept; // R4 R9

   always_comb begin
      status = '0;
      status[multidrop_pkg::ST_BUSY_BIT] = (s.st != multidrop_pkg::ST_IDLE);
      status[multidrop_pkg::ST_FULL_BIT] = !fifo_in_ready;
      status[multidrop_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
      status[multidrop_pkg::ST_REPLY_OK_BIT] = s.reply_ok;
      status[multidrop_pkg::ST_REPLY_TO_BIT] = s.reply_to;
      status[multidrop_pkg::ST_RTS_BIT] = sending;
      status[multidrop_pkg::ST_SLOT_LO +: 8] = s.slot;
   end

   always_comb begin
      next_s = s;
      next_s.fwd_valid = 1'b0;
      next_s.rdata = '0;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            multidrop_pkg::ADDR_CTRL: begin
               next_s.enable = reg_wdata[multidrop_pkg::CTRL_EN_BIT];
               next_s.drv = reg_wdata[multidrop_pkg::CTRL_DRV_LO +: 2];
            end
            multidrop_pkg::ADDR_NODES: begin
               next_s.nodes = reg_wdata[7:0]; // R5
            end
            multidrop_pkg::ADDR_PRIO: begin
               next_s.prio = reg_wdata[7:0]; // R6
            end
            multidrop_pkg::ADDR_SLICE: begin
               next_s.slice = reg_wdata[7:0]; // R5 R7 R8
            end
            multidrop_pkg::ADDR_DROP: begin
               next_s.drop = reg_wdata[7:0];
            end
            multidrop_pkg::ADDR_REPLY: begin
               next_s.reply = reg_wdata[7:0];
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end

      // Register reads, data in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            multidrop_pkg::ADDR_CTRL: begin
               next_s.rdata[multidrop_pkg::CTRL_EN_BIT] = s.enable;
               next_s.rdata[multidrop_pkg::CTRL_DRV_LO +: 2] = s.drv;
            end
            multidrop_pkg::ADDR_NODES: begin
               next_s.rdata[7:0] = s.nodes;
            end
            multidrop_pkg::ADDR_PRIO: begin
               next_s.rdata[7:0] = s.prio;
            end
            multidrop_pkg::ADDR_SLICE: begin
               next_s.rdata[7:0] = s.slice;
            end
            multidrop_pkg::ADDR_DROP: begin
               next_s.rdata[7:0] = s.drop;
            end
            multidrop_pkg::ADDR_REPLY: begin
               next_s.rdata[7:0] = s.reply;
            end
            multidrop_pkg::ADDR_STATUS: begin
               next_s.rdata = status;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end

      // Hundredth tick and slot wheel
      next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
      if (tick) begin
         next_s.slice_cnt = s.slice_cnt + 8'h01;
      end
      if (slice_end) begin
         next_s.slice_cnt = '0;
         next_s.slot = (s.slot >= s.nodes) ? multidrop_pkg::FIRST_SLOT : s.slot + 8'h01; // R14
      end
      if (tick && (s.wait_cnt != '0)) begin
         next_s.wait_cnt = s.wait_cnt - 8'h01;
      end

      // Receive filter and forwarding
      if (rx_take) begin
         next_s.rx_first = line_rx_last;
         if (s.rx_first) begin
            next_s.rx_accept = rx_ours;
         end
         if (rx_ours) begin
            next_s.fwd_data = line_rx_data; // R4
            next_s.fwd_last = line_rx_last;
            next_s.fwd_valid = 1'b1; // R4
         end
      end

      // Transmit sequence
      case (s.st)
         multidrop_pkg::ST_IDLE: begin
            if (s.enable && fifo_out_valid) begin
               next_s.st = multidrop_pkg::ST_WAIT_SLOT;
            end
         end
         multidrop_pkg::ST_WAIT_SLOT: begin
            // Turn taken only in own slot, no carrier sensing
            if (own_slot && !slice_end) begin // R1 R14
               next_s.st = multidrop_pkg::ST_WAIT_CTS;
               next_s.reply_ok = 1'b0;
               next_s.reply_to = 1'b0;
            end
         end
         multidrop_pkg::ST_WAIT_CTS: begin
            // Missing CTS gives the slot back rather than overrun it
            if (line_cts) begin // R3 R10
               next_s.st = multidrop_pkg::ST_SEND;
            end else if (slice_end) begin // R14
               next_s.st = multidrop_pkg::ST_WAIT_SLOT;
            end
         end
         multidrop_pkg::ST_SEND: begin
            if (fifo_out_ready && fifo_out.last) begin // R3
               next_s.st = multidrop_pkg::ST_WAIT_REPLY;
               next_s.wait_cnt = s.reply;
            end
         end
         multidrop_pkg::ST_WAIT_REPLY: begin
            if (rx_take && rx_ours && line_rx_last) begin // R3
               next_s.st = multidrop_pkg::ST_IDLE;
               next_s.reply_ok = 1'b1;
            end else if (s.wait_cnt == '0) begin
               next_s.st = multidrop_pkg::ST_IDLE;
               next_s.reply_to = 1'b1;
            end
         end
         default: begin
            next_s.st = multidrop_pkg::ST_IDLE;
         end
      endcase
      if (!s.enable && (s.st != multidrop_pkg::ST_SEND)) begin
         next_s.st = multidrop_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= multidrop_pkg::ST_IDLE;
         s.drv <= multidrop_pkg::RST_DRV;
         s.nodes <= multidrop_pkg::RST_NODES;
         s.prio <= multidrop_pkg::RST_PRIO;
         s.slice <= multidrop_pkg::RST_SLICE;
         s.drop <= multidrop_pkg::RST_DROP;
         s.reply <= multidrop_pkg::RST_REPLY;
         s.slot <= multidrop_pkg::FIRST_SLOT;
         s.rx_first <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign fwd_data = s.fwd_data;
   assign fwd_last = s.fwd_last;
   assign fwd_valid = s.fwd_valid;
endmodule // multidrop_line_arbiter

// ==== test/line_arbiter_monitor.sv ====
module line_arbiter_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic line_rts,
   input wire logic line_cts,
   input wire logic [7:0] line_tx_data,
   input wire logic line_tx_last,
   input wire logic line_tx_valid,
   input wire logic line_tx_ready,
   input wire logic line_rx_valid,
   input wire logic line_drv_en,
   input wire logic line_rcv_en,
   input wire logic fwd_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // Shadow of the driver field, taken from the register writes
   logic [1:0] mode;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode <= multidrop_pkg::DRV_FULL_DUPLEX;
      end else if (reg_wr && reg_addr == multidrop_pkg::ADDR_CTRL) begin
         mode <= reg_wdata[2:1];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_tx_gated: assert property (line_tx_valid |-> line_rts && line_cts)
      else $error("tx byte offered without rts and cts");
   a_full_duplex: assert property (mode == 2'h0 |-> line_drv_en && line_rcv_en)
      else $error("full duplex enables wrong");
   a_half_driver: assert property (mode == 2'h1 |-> line_drv_en && !(line_tx_valid && line_rcv_en))
      else $error("half duplex enables wrong while sending");
   a_half_listen: assert property (mode == 2'h1 && !line_rts |-> line_rcv_en)
      else $error("half duplex receiver off while idle");
   a_two_wire: assert property (mode == 2'h2 |-> (!line_drv_en || line_cts) && !(line_tx_valid && line_rcv_en))
      else $error("two wire driver not following cts");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_fwd_cause: assert property (fwd_valid |-> $past(line_rx_valid && line_rcv_en))
      else $error("forwarded byte without a received one");
   a_tx_hold: assert property (line_tx_valid && !line_tx_ready |=> $stable({line_tx_last, line_tx_data}))
      else $error("tx byte changed while stalled");
   a_last_ends: assert property (line_tx_valid && line_tx_ready && line_tx_last |=> !line_rts [*2])
      else $error("rts kept after last byte");
   c_sent: cover property (line_tx_valid && line_tx_ready && line_tx_last);
   c_stall: cover property (line_tx_valid && !line_tx_ready);
   c_fwd: cover property (fwd_valid);
endmodule // line_arbiter_monitor

bind multidrop_line_arbiter line_arbiter_monitor line_arbiter_monitor_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_rts(line_rts),
   .line_cts(line_cts), .line_tx_data(line_tx_data), .line_tx_last(line_tx_last),
   .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
   .line_rx_valid(line_rx_valid), .line_drv_en(line_drv_en),
   .line_rcv_en(line_rcv_en), .fwd_valid(fwd_valid));

// ==== test/line_partner.sv ====
module line_partner #(
   parameter int CTS_DELAY = 3
) (
   input wire logic sys_clk,
   input wire logic rts,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_valid,
   input wire logic echo,
   input wire logic stall,
   output logic cts,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   // End-of-packet flag kept beside each byte so the marker is checked too
   logic [8:0] got[$];
   int wait_n = 0;
   logic phase = 1'b0;
   logic busy = 1'b0;
   initial begin
      cts = 1'b0;
      tx_ready = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      rx_valid = 1'b0;
   end
   // Slow modem: cts only after a delay, dropped with rts
   always @(posedge sys_clk) begin
      wait_n <= rts ? wait_n + 1 : 0;
      cts <= rts && wait_n >= CTS_DELAY;
      phase <= !phase;
      tx_ready <= !stall || phase;
      if (tx_valid && tx_ready) begin
         got.push_back({tx_last, tx_data});
      end
      if (echo && tx_valid && tx_ready) begin
         rx_data <= tx_data;
         rx_last <= tx_last;
         rx_valid <= 1'b1;
      end else if (!busy) begin
         // Idle line shows no stale byte
         rx_data <= ~rx_data;
         rx_valid <= 1'b0;
      end
   end
   task automatic send_pkt(input logic [7:0] pkt[$]);
      busy = 1'b1;
      foreach (pkt[i]) begin
         @(posedge sys_clk);
         rx_data <= pkt[i];
         rx_last <= i == pkt.size() - 1;
         rx_valid <= 1'b1;
      end
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      busy = 1'b0;
   endtask
endmodule // line_partner

// ==== test/multidrop_line_arbiter_tb.sv ====
module multidrop_line_arbiter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic echo = 1'b0;
   logic stall = 1'b0;
   logic [15:0] reg_rdata;
   logic [7:0] line_tx_data, line_rx_data, fwd_data;
   logic line_rts, line_cts, line_tx_last, line_tx_valid, line_tx_ready;
   logic line_rx_last, line_rx_valid, line_drv_en, line_rcv_en, fwd_last, fwd_valid;
   int failures = 0;
   int n_compared = 0;
   logic [8:0] fwd_q[$];
   logic [15:0] v;
   multidrop_line_arbiter #(.HUNDREDTH_CYCLES(20)) multidrop_line_arbiter_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_rts(line_rts),
      .line_cts(line_cts), .line_tx_data(line_tx_data), .line_tx_last(line_tx_last),
      .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
      .line_rx_data(line_rx_data), .line_rx_last(line_rx_last),
      .line_rx_valid(line_rx_valid), .line_drv_en(line_drv_en), .line_rcv_en(line_rcv_en),
      .fwd_data(fwd_data), .fwd_last(fwd_last), .fwd_valid(fwd_valid));
   line_partner line_partner_i (
      .sys_clk(sys_clk), .rts(line_rts), .tx_data(line_tx_data), .tx_last(line_tx_last),
      .tx_valid(line_tx_valid), .echo(echo), .stall(stall), .cts(line_cts),
      .tx_ready(line_tx_ready), .rx_data(line_rx_data), .rx_last(line_rx_last),
      .rx_valid(line_rx_valid));
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (fwd_valid) begin
         fwd_q.push_back({fwd_last, fwd_data});
      end
   end
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic wait_rts(input logic lvl);
      int n;
      n = 0;
      while (line_rts !== lvl && n < 600) begin
         @(posedge sys_clk);
         #1 n++;
      end
      cmp("rts", {15'h0000, lvl}, {15'h0000, line_rts});
      @(posedge sys_clk);
   endtask
   task automatic reset_values;
      rd(multidrop_pkg::ADDR_NODES);
      cmp("nodes", 16'h0001, v);
      rd(multidrop_pkg::ADDR_REPLY);
      cmp("reply", 16'h0032, v);
      rd(multidrop_pkg::ADDR_STATUS);
      cmp("status", 16'h0104, v);
      rd(4'h8);
      cmp("unmapped", 16'h0000, v);
      cmp("enables", 16'h0003, {14'h0000, line_drv_en, line_rcv_en});
   endtask
   task automatic rx_filter;
      wr(multidrop_pkg::ADDR_DROP, 16'h0011);
      wr(multidrop_pkg::ADDR_CTRL, 16'h0001);
      line_partner_i.send_pkt('{8'h33, 8'h44, 8'h55});
      line_partner_i.send_pkt('{8'h11, 8'h66, 8'h77});
      repeat (4) @(posedge sys_clk);
      cmp("fwd count", 16'h0003, 16'(fwd_q.size()));
      cmp("fwd last", 16'h0177, {7'h00, fwd_q[2]});
   endtask
   task automatic tx_two_wire;
      wr(multidrop_pkg::ADDR_CTRL, 16'h0004);
      wr(multidrop_pkg::ADDR_NODES, 16'h0003);
      wr(multidrop_pkg::ADDR_PRIO, 16'h0002);
      wr(multidrop_pkg::ADDR_SLICE, 16'h0005);
      wr(multidrop_pkg::ADDR_REPLY, 16'h0002);
      for (int i = 0; i < 9; i++) begin
         wr(multidrop_pkg::ADDR_TXDATA, i == 0 ? 16'h0022 : (i == 7 ? 16'h0137 : 16'h0030 + i));
      end
      rd(multidrop_pkg::ADDR_STATUS);
      cmp("queue full", 16'h0002, v & 16'h0007);
      stall <= 1'b1;
      wr(multidrop_pkg::ADDR_CTRL, 16'h0005);
      wait_rts(1'b1);
      rd(multidrop_pkg::ADDR_STATUS);
      cmp("own slot", 16'h0002, v >> 8);
      wait_rts(1'b0);
      cmp("sent count", 16'h0008, 16'(line_partner_i.got.size()));
      foreach (line_partner_i.got[i]) begin
         v = i == 0 ? 16'h0022 : (i == 7 ? 16'h0137 : 16'h0030 + 16'(i));
         cmp("sent byte", v, {7'h00, line_partner_i.got[i]});
      end
      line_partner_i.send_pkt('{8'h11, 8'h99});
      rd(multidrop_pkg::ADDR_STATUS);
      cmp("reply ok", 16'h0008, v & 16'h0019);
   endtask
   task automatic tx_half_echo;
      stall <= 1'b0;
      echo <= 1'b1;
      line_partner_i.got.delete();
      wr(multidrop_pkg::ADDR_CTRL, 16'h0003);
      wr(multidrop_pkg::ADDR_TXDATA, 16'h0022);
      wr(multidrop_pkg::ADDR_TXDATA, 16'h01AB);
      fwd_q.delete();
      wait_rts(1'b1);
      wait_rts(1'b0);
      // Reply window is two hundredths of 20 cycles
      repeat (60) @(posedge sys_clk);
      rd(multidrop_pkg::ADDR_STATUS);
      cmp("reply timeout", 16'h0010, v & 16'h0019);
      cmp("echo dropped", 16'h0000, 16'(fwd_q.size()));
      cmp("echo sent", 16'h0002, 16'(line_partner_i.got.size()));
   endtask
   task automatic end_of_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #(50 * 20000);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      reset_values();
      rx_filter();
      tx_two_wire();
      tx_half_echo();
      end_of_test();
   end
endmodule // multidrop_line_arbiter_tb
